// ===== hdl/cap_trig_defines.svh
// Offsets, field positions, reset values for the capture trigger selector.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CAP_TRIG_DEFINES_SVH
`define CAP_TRIG_DEFINES_SVH

// ***************************************************
// Register map
// ***************************************************
`define CAP0_TRG_OFFSET 8'h5C
`define CAP1_TRG_OFFSET 8'h60
`define CAP0_TRG_RESET 32'h00000000
`define CAP1_TRG_RESET 32'h00000000
`define UNMAPPED_READ 32'h00000000

// ***************************************************
// Field positions
// ***************************************************
`define BIT_SW 0
`define BIT_UPD 1
`define BIT_EXT0 2
`define BIT_SIB_BASE 12
`define NUM_EXT 10
`define NUM_SIB 5

`endif

// ===== hdl/cap_trig_pkg.sv
// Types shared by the capture trigger selector files.
// Assumes nothing beyond a SystemVerilog compiler.
package cap_trig_pkg;
    // Slave bus phase for the read channel
    typedef enum logic [1:0] {
        bus_idle,
        bus_resp
    } bus_state_t;
endpackage

// ===== hdl/sib_source_gate.sv
// One sibling timer's four capture sources gated by their enable bits.
// Assumes the sibling signals are synchronous to clk_i.
`timescale 1ns/1ns
`include "cap_trig_defines.svh"
module sib_source_gate (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ch0_out_i,
    input wire logic cmp0_i,
    input wire logic cmp1_i,
    input wire logic [3:0] enable_i,
    output logic hit_o
);
    logic out_prev; // Last channel output level

    // ***************************************************
    // Channel output edge memory
    // ***************************************************
    // Previous level, reset inactive so no edge at start
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            out_prev <= 1'b0;
        end else begin
            out_prev <= ch0_out_i;
        end
    end

    // Enable order: rise, fall, compare 0, compare 1
    always_comb begin
        hit_o = (enable_i[0] & ch0_out_i & ~out_prev)
            | (enable_i[1] & ~ch0_out_i & out_prev)
            | (enable_i[2] & cmp0_i)
            | (enable_i[3] & cmp1_i);
    end
endmodule

// ===== hdl/capture0_trigger_select.sv
// Capture 0 trigger selection for slave timers 5 to 7, with AXI4-Lite slave.
// Assumes all event inputs are one-cycle pulses or levels on clk_i.
`timescale 1ns/1ns
`include "cap_trig_defines.svh"
module capture0_trigger_select (
    input wire logic clk_i,
    input wire logic nrst_i,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event sources
    input wire logic update_event_i,
    input wire logic [9:0] ext_event_i,
    input wire logic [4:0] sib_channel0_output_i,
    input wire logic [4:0] sib_cmp0_i,
    input wire logic [4:0] sib_cmp1_i,
    // Capture 0 strobe and capture 1 selection
    output logic capture0_strobe_o,
    output logic [31:0] capture1_select_o
);
    // ***************************************************
    // Storage
    // ***************************************************
    logic [31:0] cap0_sel; // Capture 0 enables
    logic [31:0] cap1_sel; // Capture 1 selection, opaque
    logic aw_held; // Write address taken
    logic w_held; // Write data taken
    logic [7:0] aw_addr; // Held write address
    logic [31:0] w_data; // Held write data
    logic [3:0] w_strb; // Held byte enables
    cap_trig_pkg::bus_state_t rd_state; // Read channel phase
    logic [4:0] sib_hit; // Per-sibling gated hits
    logic ext_hit; // Any enabled external event
    logic next_strobe; // Combined trigger this cycle
    logic wr_go; // Both write halves present
    logic sw_write; // Write sets software bit now

    // ***************************************************
    // Write channel: address and data in either order
    // ***************************************************
    // Each half is parked in its own holding register.
    // The commit waits until both halves are present.
    // Readiness stays low from the handshake until the
    // response is taken, so one write is under way at a time.
    // The cost is one idle cycle between writes; the gain is
    // that no address can pair with the data of another write.
    assign wr_go = aw_held & w_held & ~s_axi_bvalid;

    // Address acceptance
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end else begin
            // Ready only while nothing pending
            s_axi_awready <= ~aw_held & ~s_axi_bvalid;
        end
    end

    // Data acceptance
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end else begin
            s_axi_wready <= ~w_held & ~s_axi_bvalid;
        end
    end

    // Response after both halves; unmapped gives SLVERR
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == `CAP0_TRG_OFFSET || aw_addr == `CAP1_TRG_OFFSET) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ***************************************************
    // Registers
    // ***************************************************
    assign sw_write = wr_go & (aw_addr == `CAP0_TRG_OFFSET) & w_strb[0] & w_data[`BIT_SW];

    // Capture 0 enables; software bit clears one cycle after set
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cap0_sel <= `CAP0_TRG_RESET;
        end else if (wr_go && aw_addr == `CAP0_TRG_OFFSET) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    cap0_sel[b*8 +: 8] <= w_data[b*8 +: 8];
                end
            end
        end else begin
            cap0_sel[`BIT_SW] <= 1'b0;
        end
    end

    // Capture 1 register; only word writes land, partial ones dropped
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cap1_sel <= `CAP1_TRG_RESET;
        end else if (wr_go && aw_addr == `CAP1_TRG_OFFSET && w_strb == 4'hF) begin
            cap1_sel <= w_data;
        end else begin
            cap1_sel[`BIT_SW] <= 1'b0;
        end
    end

    // ***************************************************
    // Read channel
    // ***************************************************
    // Address ready toggles while idle, so a request waits
    // at most one cycle for it. Data are captured at the
    // handshake edge and stand until the master takes them.
    // Reading never disturbs the stored enables.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_state <= cap_trig_pkg::bus_idle;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            case (rd_state)
                cap_trig_pkg::bus_idle: begin
                    s_axi_arready <= ~s_axi_arready;
                    if (s_axi_arvalid & s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        rd_state <= cap_trig_pkg::bus_resp;
                        // Decode; unmapped reads zero with SLVERR
                        if (s_axi_araddr == `CAP0_TRG_OFFSET) begin
                            s_axi_rdata <= cap0_sel;
                            s_axi_rresp <= 2'h0;
                        end else if (s_axi_araddr == `CAP1_TRG_OFFSET) begin
                            s_axi_rdata <= cap1_sel;
                            s_axi_rresp <= 2'h0;
                        end else begin
                            s_axi_rdata <= `UNMAPPED_READ;
                            s_axi_rresp <= 2'h2;
                        end
                    end
                end
                cap_trig_pkg::bus_resp: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state <= cap_trig_pkg::bus_idle;
                    end
                end
                default: begin
                    rd_state <= cap_trig_pkg::bus_idle;
                end
            endcase
        end
    end

    // ***************************************************
    // Trigger sources
    // ***************************************************
    // Every source is sampled on clk_i with no synchroniser:
    // the siblings and the event logic share this clock.
    // A source that arrives from another clock domain must
    // be synchronised before it reaches these inputs.
    // One gate per sibling timer, four enable bits each
    for (genvar s = 0; s < `NUM_SIB; s++) begin : g_sib
        sib_source_gate u_gate (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .ch0_out_i(sib_channel0_output_i[s]),
            .cmp0_i(sib_cmp0_i[s]),
            .cmp1_i(sib_cmp1_i[s]),
            .enable_i(cap0_sel[`BIT_SIB_BASE + 4*s +: 4]),
            .hit_o(sib_hit[s])
        );
    end

    assign ext_hit = |(ext_event_i & cap0_sel[`BIT_EXT0 +: `NUM_EXT]);

    // Any enabled source gives one strobe
    assign next_strobe = cap0_sel[`BIT_SW]
        | (cap0_sel[`BIT_UPD] & update_event_i)
        | ext_hit
        | (|sib_hit);

    // Registered strobe output
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            capture0_strobe_o <= 1'b0;
            capture1_select_o <= 32'h00000000;
        end else begin
            capture0_strobe_o <= next_strobe;
            capture1_select_o <= cap1_sel;
        end
    end

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_sw_self_clear: assert property (sw_write |=> cap0_sel[`BIT_SW] ##1 !cap0_sel[`BIT_SW])
        else $error("software bit not self cleared");
    a_sw_fires: assert property (sw_write |=> ##1 capture0_strobe_o)
        else $error("software capture missing");
    a_upd_fires: assert property (cap0_sel[`BIT_UPD] && update_event_i |=> capture0_strobe_o)
        else $error("update capture missing");
    a_ext_fires: assert property ((ext_event_i & cap0_sel[11:2]) != 10'h000 |=> capture0_strobe_o)
        else $error("external capture missing");
    a_cmp_fires: assert property (cap0_sel[14] && sib_cmp0_i[0] |=> capture0_strobe_o)
        else $error("sibling compare capture missing");
    a_fall_fires: assert property (cap0_sel[13] && $fell(sib_channel0_output_i[0]) |=> capture0_strobe_o)
        else $error("fall capture missing");
    a_rise_fires: assert property (cap0_sel[12] && $rose(sib_channel0_output_i[0]) |=> capture0_strobe_o)
        else $error("rise capture missing");
    a_sib4_fires: assert property (cap0_sel[31] && sib_cmp1_i[4] |=> capture0_strobe_o)
        else $error("sibling 4 capture missing");
    a_no_spurious: assert property (!next_strobe |=> !capture0_strobe_o)
        else $error("strobe without source");
    a_cap1_word: assert property (wr_go && aw_addr == `CAP1_TRG_OFFSET && w_strb != 4'hF |=> $stable(cap1_sel[31:1]))
        else $error("partial capture 1 write landed");

    // ***************************************************
    // Further source map checks
    // ***************************************************
    // One check each for siblings 0 to 3, picking a different
    // source kind each time so every kind is watched.
    // External event 9 at the top of the external field
    a_ext9_fires: assert property (cap0_sel[11] && ext_event_i[9] |=> capture0_strobe_o)
        else $error("external event 9 capture missing");
    // Sibling 1 channel falling edge
    a_sib1_fall: assert property (cap0_sel[17] && $fell(sib_channel0_output_i[1]) |=> capture0_strobe_o)
        else $error("sibling 1 fall capture missing");
    // Sibling 2 compare 0
    a_sib2_cmp0: assert property (cap0_sel[22] && sib_cmp0_i[2] |=> capture0_strobe_o)
        else $error("sibling 2 compare capture missing");
    // Sibling 3 channel rising edge
    a_sib3_rise: assert property (cap0_sel[24] && $rose(sib_channel0_output_i[3]) |=> capture0_strobe_o)
        else $error("sibling 3 rise capture missing");
    // Sibling 0 compare 1
    a_sib0_cmp1: assert property (cap0_sel[15] && sib_cmp1_i[0] |=> capture0_strobe_o)
        else $error("sibling 0 compare 1 capture missing");

    // ***************************************************
    // Bus protocol checks
    // ***************************************************
    // Answers must stand until the master takes them.
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
        else $error("write response code changed");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    // No new write is taken while a response is pending
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    // Capture 0 reads return the stored enables
    a_cap0_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `CAP0_TRG_OFFSET
        |=> s_axi_rdata == $past(cap0_sel))
        else $error("capture 0 read data wrong");
    // Unmapped reads give zero with an error code
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != `CAP0_TRG_OFFSET
        && s_axi_araddr != `CAP1_TRG_OFFSET |=> s_axi_rresp == 2'h2 && s_axi_rdata == `UNMAPPED_READ)
        else $error("unmapped read not refused");
    // Unmapped writes leave both registers alone
    a_wr_unmapped: assert property (wr_go && aw_addr != `CAP0_TRG_OFFSET && aw_addr != `CAP1_TRG_OFFSET
        |=> $stable(cap0_sel[31:1]) && $stable(cap1_sel[31:1]))
        else $error("unmapped write landed");

    // ***************************************************
    // Scenario covers
    // ***************************************************
    // Covers show the main paths are reached by stimulus.
    c_wr_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
    c_sw: cover property (sw_write ##2 capture0_strobe_o);
    c_rise: cover property (cap0_sel[16] && $rose(sib_channel0_output_i[1]));
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== verification/event_source_model.sv
// Far-side model: update, external and sibling timer event sources.
// Assumes the bench calls fire() from its main sequence, one call at a time.
`timescale 1ns/1ns
module event_source_model (
    input wire logic clk_i,
    output logic update_o,
    output logic [9:0] ext_o,
    output logic [4:0] ch0_o,
    output logic [4:0] cmp0_o,
    output logic [4:0] cmp1_o
);
    // ********************
    // Idle sources
    // ********************
    // Quiet at time zero; channel outputs start inactive (low)
    initial begin
        update_o = 1'h0;
        ext_o = 10'h000;
        ch0_o = 5'h00;
        cmp0_o = 5'h00;
        cmp1_o = 5'h00;
    end
    // One-cycle pulses by control word position.
    // A channel output toggles and returns, so rise and fall each occur once.
    task automatic fire(input logic [31:0] src);
        logic [4:0] tog;
        tog = 5'h00;
        @(posedge clk_i);
        update_o <= src[1];
        ext_o <= src[11:2];
        for (int s = 0; s < 5; s++) begin
            cmp0_o[s] <= src[14 + 4 * s];
            cmp1_o[s] <= src[15 + 4 * s];
            tog[s] = |src[12 + 4 * s +: 2];
        end
        ch0_o <= ch0_o ^ tog;
        @(posedge clk_i);
        // Drop pulses, bring channel outputs back
        update_o <= 1'h0;
        ext_o <= 10'h000;
        cmp0_o <= 5'h00;
        cmp1_o <= 5'h00;
        ch0_o <= ch0_o ^ tog;
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the capture 0 trigger selector.
// Assumes the design files and the event source model are compiled first.
`timescale 1ns/1ns
`include "cap_trig_defines.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    logic clk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, capture1_select_o;
    wire logic capture0_strobe_o, upd;
    wire logic [9:0] ext;
    wire logic [4:0] ch0, c0, c1;
    int bad_count = 0, comparisons = 0, strobes = 0, seed = 47;
    logic [33:0] rq[$]; // Expected {rresp, rdata}
    logic [1:0] bq[$]; // Expected bresp
    logic [31:0] m;
    int src;
    int exp_n; // Expected strobe count for one random source
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    event_source_model u_src (.clk_i, .update_o(upd), .ext_o(ext), .ch0_o(ch0), .cmp0_o(c0), .cmp1_o(c1));
    capture0_trigger_select u_dut (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .update_event_i(upd), .ext_event_i(ext),
        .sib_channel0_output_i(ch0), .sib_cmp0_i(c0), .sib_cmp1_i(c1), .capture0_strobe_o,
        .capture1_select_o);
    // ********************
    // Output watcher
    // ********************
    // Pops the oldest note per bus answer; counts capture strobes
    always @(posedge clk_i) begin
        if (s_axi_bvalid && s_axi_bready) begin
            `CHK(s_axi_bresp, bq.pop_front())
        end
        if (s_axi_rvalid && s_axi_rready) begin
            `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        end
        if (capture0_strobe_o === 1'h1) begin
            strobes++;
        end
    end
    // ********************
    // Bus and event tasks
    // ********************
    // Write with the given byte strobes; each channel released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
        bq.push_back(r);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    // Read with expected data and response noted first
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    // Fire sources, then count strobes after the one-cycle latency
    task automatic fire_chk(input logic [31:0] s, input int e);
        int s0;
        s0 = strobes;
        u_src.fire(s);
        repeat (3) @(posedge clk_i);
        `CHK(strobes - s0, e)
    endtask
    // Counts, verdict, end of run
    task automatic final_report;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'h1;
        rd(`CAP0_TRG_OFFSET, 32'h0, 2'h0);
        rd(`CAP1_TRG_OFFSET, 32'h0, 2'h0);
        rd(8'h10, 32'h0, 2'h2);
        wr(8'h10, 32'hFFFFFFFF, 4'hF, 2'h2);
        $display("Reset and map test done");
        wr(`CAP1_TRG_OFFSET, 32'hA5A5A5A4, 4'hF, 2'h0);
        // Exported copy trails the register by one cycle; look once settled
        repeat (2) @(negedge clk_i);
        `CHK(capture1_select_o, 32'hA5A5A5A4)
        wr(`CAP1_TRG_OFFSET, 32'h0, 4'h1, 2'h0);
        rd(`CAP1_TRG_OFFSET, 32'hA5A5A5A4, 2'h0);
        $display("Capture 1 register test done");
        // Each enable from bit 1 alone: its own source fires, the one two bits up (wrapping) does not
        for (int b = 1; b < 32; b++) begin
            wr(`CAP0_TRG_OFFSET, 32'h1 << b, 4'hF, 2'h0);
            fire_chk(32'h1 << b, 1);
            fire_chk(32'h1 << ((b + 1) % 31 + 1), 0);
        end
        $display("Source map test done");
        src = strobes;
        wr(`CAP0_TRG_OFFSET, 32'h3, 4'hF, 2'h0);
        repeat (3) @(posedge clk_i);
        `CHK(strobes - src, 1)
        rd(`CAP0_TRG_OFFSET, 32'h2, 2'h0);
        $display("Software capture test done");
        wr(`CAP0_TRG_OFFSET, 32'hFFFFFFFE, 4'hF, 2'h0);
        fire_chk(32'h0000C006, 1);
        $display("Combined source test done");
        for (int i = 0; i < 40; i++) begin
            m = $random(seed);
            m[0] = 1'h0;
            src = 1 + ($unsigned($random(seed)) % 31);
            wr(`CAP0_TRG_OFFSET, m, 4'hF, 2'h0);
            // A channel pulse gives a rise and a fall, so both edge enables count
            exp_n = int'(m[src]);
            if (src >= 12 && ((src - 12) % 4) < 2) begin
                exp_n = int'(m[src & ~1]) + int'(m[src | 1]);
            end
            fire_chk(32'h1 << src, exp_n);
        end
        $display("Random mask test done");
        final_report;
    end
    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #400000;
        bad_count++;
        final_report;
    end
endmodule
